//--- inc/gate_pkg.sv
package gate_pkg;

  // Clock and timing.
  localparam int CLK_PERIOD_PS    = 5000;
  localparam int STOP_HOLD_NS     = 100;
  localparam int STOP_HOLD_CYC    = (STOP_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int STOP_CNT_W       = 8;

  // Default geometry.
  localparam int NUM_CHANNELS     = 16;
  localparam int DATA_W           = 16;
  localparam int FILT_W           = 7;
  localparam int TIMER_W          = 48;

  // Synchroniser bit positions.
  localparam int SYNC_VETO_BIT    = 0;
  localparam int SYNC_RUN_BIT     = 1;
  localparam int SYNC_W           = 2;

  // Run control states, Gray coded along idle, init, wait, run, stop.
  typedef enum logic [2:0] {
    RUN_IDLE = 3'h0,
    RUN_INIT = 3'h1,
    RUN_WAIT = 3'h3,
    RUN_ACQ  = 3'h2,
    RUN_STOP = 3'h6
  } run_state_t;

endpackage

//--- logic/sync_two_stage.sv
`timescale 1ns/1ps
module sync_two_stage #(
  parameter int W = 1
) (
  // Clock and reset.
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic         i_ce,
  // Data.
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);

  logic [W-1:0] meta_q;

  // The first stage feeds only the second stage.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_q <= '0;
      o_q    <= '0;
    end else if (i_ce) begin
      meta_q <= i_d;
      o_q    <= meta_q;
    end
  end

endmodule

//--- logic/event_latch_validation_gate.sv
`timescale 1ns/1ps
// Functional notes
// - Validated channels latch only with validation high.
// - Latch between rise and rise plus flat.
// - No external fast trigger; only confirms events.
// - Per-channel validation requirement setting.
// - Front panel can drive validation onto veto.
// - Waiting shows align flag and wait setting.
// - Software can force exit from hung wait.
// - Configuration answers only with valid clock.
// - Pull run line during init, start on rise.
// - End of run pulls line, others stop.
// - Align flag zero clears timers on exit.
module event_latch_validation_gate #(
  parameter int NCH = gate_pkg::NUM_CHANNELS,
  parameter int DW  = gate_pkg::DATA_W,
  parameter int FW  = gate_pkg::FILT_W
) (
  // Clock, reset and enable.
  input  wire logic                 i_clk,
  input  wire logic                 i_rst,
  input  wire logic                 i_ce,
  // Own trigger detection and event data per channel.
  input  wire logic [NCH-1:0]       i_event_recognized,
  input  wire logic [NCH*DW-1:0]    i_event_data,
  input  wire logic [NCH-1:0]       i_require_validation,
  input  wire logic [FW-1:0]        i_rise_cycles,
  input  wire logic [FW-1:0]        i_flat_cycles,
  // Latched results.
  output logic      [NCH*DW-1:0]    o_latched_data,
  output logic      [NCH-1:0]       o_latch_valid,
  output logic      [NCH-1:0]       o_latch_rejected,
  // Backplane veto line and front panel.
  input  wire logic                 i_backplane_veto_line,
  output logic                      o_backplane_veto_line_oe,
  input  wire logic                 i_fp_validation_in,
  input  wire logic                 i_fp_route_validation,
  // Run synchronisation.
  input  wire logic                 i_run_start_req,
  input  wire logic                 i_init_done,
  input  wire logic                 i_end_of_run,
  input  wire logic                 i_force_wait_exit,
  input  wire logic                 i_run_start_wait_enable,
  input  wire logic                 i_timer_align_cfg,
  input  wire logic                 i_run_line,
  output logic                      o_run_line_oe,
  output logic                      o_run_start_wait_enable,
  output logic                      o_timer_align_pending,
  output logic                      o_acquiring,
  output logic [gate_pkg::TIMER_W-1:0] o_timer,
  output logic                      o_cfg_respond_en
);

  localparam int CW     = FW + 1;
  localparam int STOP_W = gate_pkg::STOP_CNT_W;

  // The stop hold count must fit its counter, or the run line would be released early.
  if (NCH < 1 || DW < 1 || FW < 2 ||
      gate_pkg::STOP_HOLD_CYC >= (1 << STOP_W)) begin : g_bad_param
    $error("Unsupported channel, data, filter or stop counter width.");
  end

  // Sum of rise and flat top, one bit wider so it cannot wrap.
  function automatic logic [CW-1:0] window_end(input logic [FW-1:0] r, input logic [FW-1:0] f);
    window_end = {1'b0, r} + {1'b0, f};
  endfunction

  logic [gate_pkg::SYNC_W-1:0] sync_s;
  logic                        veto_s;
  logic                        run_s;
  logic                        run_prev_q;
  logic [NCH-1:0]              busy_q;
  logic [CW-1:0]               cnt_q [NCH];
  logic [CW-1:0]               win_end;
  gate_pkg::run_state_t        state_q;
  logic [STOP_W-1:0]           stop_cnt_q;

  sync_two_stage #(
    .W (gate_pkg::SYNC_W)
  ) u_sync (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .i_ce  (i_ce),
    .i_d   ({i_run_line, i_backplane_veto_line}),
    .o_q   (sync_s)
  );

  assign veto_s  = sync_s[gate_pkg::SYNC_VETO_BIT];
  assign run_s   = sync_s[gate_pkg::SYNC_RUN_BIT];
  assign win_end = window_end(i_rise_cycles, i_flat_cycles);

  // only own detection arms a channel.
  // A channel that is busy ignores further recognitions; pileup is the filter's concern.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      busy_q <= '0;
      for (int c = 0; c < NCH; c++) begin
        cnt_q[c] <= '0;
      end
    end else if (i_ce) begin
      for (int c = 0; c < NCH; c++) begin
        if (!busy_q[c] && i_event_recognized[c] && o_acquiring) begin
          busy_q[c] <= 1'b1;
          cnt_q[c]  <= CW'(1);
        end else if (busy_q[c]) begin
          if (cnt_q[c] >= win_end) begin
            busy_q[c] <= 1'b0;
          end
          cnt_q[c] <= cnt_q[c] + CW'(1);
        end
      end
    end
  end

  // latch at end of flat top.
  // Latching at the late edge gives the partner the longest decision time.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_latched_data   <= '0;
      o_latch_valid    <= '0;
      o_latch_rejected <= '0;
    end else if (i_ce) begin
      for (int c = 0; c < NCH; c++) begin
        o_latch_valid[c]    <= 1'b0;
        o_latch_rejected[c] <= 1'b0;
        if (busy_q[c] && cnt_q[c] >= win_end) begin
          if (!i_require_validation[c] || veto_s) begin
            o_latched_data[c*DW +: DW] <= i_event_data[c*DW +: DW];
            o_latch_valid[c]           <= 1'b1;
          end else begin
            o_latch_rejected[c] <= 1'b1;
          end
        end
      end
    end
  end

  // front panel onto veto.
  // Open drain can only pull low, so a low front-panel level is what gets driven.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_backplane_veto_line_oe <= 1'b0;
    end else if (i_ce) begin
      o_backplane_veto_line_oe <= i_fp_route_validation & ~i_fp_validation_in;
    end
  end

  // Run control state machine.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q    <= gate_pkg::RUN_IDLE;
      stop_cnt_q <= '0;
      run_prev_q <= 1'b0;
    end else if (i_ce) begin
      run_prev_q <= run_s;
      case (state_q)
        gate_pkg::RUN_IDLE: begin
          if (i_run_start_req) begin
            state_q <= gate_pkg::RUN_INIT;
          end
        end
        gate_pkg::RUN_INIT: begin
          if (i_init_done) begin
            state_q <= o_run_start_wait_enable ? gate_pkg::RUN_WAIT : gate_pkg::RUN_ACQ;
          end
        end
        gate_pkg::RUN_WAIT: begin
          if (i_force_wait_exit) begin
            state_q <= gate_pkg::RUN_IDLE;
          end else if (run_s && !run_prev_q) begin
            state_q <= gate_pkg::RUN_ACQ;
          end
        end
        gate_pkg::RUN_ACQ: begin
          if (i_end_of_run) begin
            state_q    <= gate_pkg::RUN_STOP;
            stop_cnt_q <= STOP_W'(gate_pkg::STOP_HOLD_CYC);
          end else if (o_run_start_wait_enable && !run_s) begin
            state_q <= gate_pkg::RUN_IDLE;
          end
        end
        gate_pkg::RUN_STOP: begin
          if (stop_cnt_q <= STOP_W'(1)) begin
            state_q <= gate_pkg::RUN_IDLE;
          end
          stop_cnt_q <= stop_cnt_q - STOP_W'(1);
        end
        default: begin
          state_q <= gate_pkg::RUN_IDLE;
        end
      endcase
    end
  end

  // settings captured and readable.
  // Settings are frozen at run start so a stuck wait reads back consistently.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_run_start_wait_enable <= 1'b0;
      o_timer_align_pending   <= 1'b1;
    end else if (i_ce && state_q == gate_pkg::RUN_IDLE) begin
      o_run_start_wait_enable <= i_run_start_wait_enable;
      o_timer_align_pending   <= i_timer_align_cfg;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_timer <= '0;
    end else if (i_ce) begin
      if (state_q == gate_pkg::RUN_WAIT && run_s && !run_prev_q && !i_force_wait_exit
          && !o_timer_align_pending) begin
        o_timer <= '0;
      end else begin
        o_timer <= o_timer + gate_pkg::TIMER_W'(1);
      end
    end
  end

  assign o_run_line_oe = o_run_start_wait_enable &&
                         (state_q == gate_pkg::RUN_INIT || state_q == gate_pkg::RUN_STOP);
  assign o_acquiring   = (state_q == gate_pkg::RUN_ACQ);

  // answer only when clocked.
  // This flop can only rise on a real clock edge, so no clock means no answer.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_cfg_respond_en <= 1'b0;
    end else begin
      o_cfg_respond_en <= 1'b1;
    end
  end

  property p_valid_gate;
    @(posedge i_clk) disable iff (i_rst)
      (o_latch_valid[0] && $past(i_require_validation[0])) |-> $past(veto_s);
  endproperty
  a_valid_gate: assert property (p_valid_gate) else $error("Latch without validation.");

  property p_latch_time;
    @(posedge i_clk) disable iff (i_rst)
      (o_latch_valid[0] || o_latch_rejected[0]) |->
        ($past(cnt_q[0]) == $past(win_end)) && ($past(cnt_q[0]) > {1'b0, $past(i_rise_cycles)});
  endproperty
  a_latch_time: assert property (p_latch_time) else $error("Latch outside window.");

  property p_reject;
    @(posedge i_clk) disable iff (i_rst)
      (i_ce && busy_q[0] && cnt_q[0] >= win_end && i_require_validation[0] && !veto_s)
        |=> o_latch_rejected[0] && !o_latch_valid[0];
  endproperty
  a_reject: assert property (p_reject) else $error("Missing rejection.");

  property p_wait_flag;
    @(posedge i_clk) disable iff (i_rst)
      (state_q == gate_pkg::RUN_WAIT) |-> o_run_start_wait_enable && !o_run_line_oe;
  endproperty
  a_wait_flag: assert property (p_wait_flag) else $error("Wait flags wrong.");

  property p_force_exit;
    @(posedge i_clk) disable iff (i_rst)
      (i_ce && state_q == gate_pkg::RUN_WAIT && i_force_wait_exit)
        |=> state_q == gate_pkg::RUN_IDLE;
  endproperty
  a_force_exit: assert property (p_force_exit) else $error("Forced exit ignored.");

  property p_init_pull;
    @(posedge i_clk) disable iff (i_rst)
      (i_ce && state_q == gate_pkg::RUN_IDLE && i_run_start_req && i_run_start_wait_enable)
        |=> o_run_line_oe;
  endproperty
  a_init_pull: assert property (p_init_pull) else $error("Run line not pulled.");

  property p_end_pull;
    @(posedge i_clk) disable iff (i_rst)
      (i_ce && o_acquiring && i_end_of_run && o_run_start_wait_enable)
        |=> o_run_line_oe [*2];
  endproperty
  a_end_pull: assert property (p_end_pull) else $error("Stop not signalled.");

  property p_timer_clear;
    @(posedge i_clk) disable iff (i_rst)
      (i_ce && state_q == gate_pkg::RUN_WAIT && run_s && !run_prev_q && !i_force_wait_exit
       && !o_timer_align_pending) |=> o_timer == '0 && o_acquiring;
  endproperty
  a_timer_clear: assert property (p_timer_clear) else $error("Timer not cleared.");

  property p_sync;
    @(posedge i_clk) disable iff (i_rst)
      ($past(i_ce) && $past(i_ce, 2) && !$past(i_rst, 2))
        |-> veto_s == $past(i_backplane_veto_line, 2);
  endproperty
  a_sync: assert property (p_sync) else $error("Sync latency wrong.");

  property p_fp_route;
    @(posedge i_clk) disable iff (i_rst)
      (i_ce && i_fp_route_validation && !i_fp_validation_in) |=> o_backplane_veto_line_oe;
  endproperty
  a_fp_route: assert property (p_fp_route) else $error("Front panel not routed.");

endmodule

//--- tb/veto_partner.sv
`timescale 1ns/1ps
// Far-side trigger logic on the veto line; it only pulls the line low, to reject.
module veto_partner (
  // Clock and event notice.
  input  wire logic       i_clk,
  input  wire logic       i_event,
  input  wire logic       i_accept,
  input  wire logic [6:0] i_span,
  // High pulls the shared veto line low.
  output logic            o_pull = 1'b0
);
  logic [7:0] cnt_q = 8'h00;

  // The verdict is set on the event edge and held past the whole filter window.
  // decide at once
  always @(posedge i_clk) begin
    if (i_event) begin
      cnt_q <= 8'h01;
      o_pull <= !i_accept;
    end else if (cnt_q != 8'h00) begin
      cnt_q <= (cnt_q > {1'b0, i_span} + 8'h02) ? 8'h00 : cnt_q + 8'h01;
      o_pull <= (cnt_q > {1'b0, i_span} + 8'h02) ? 1'b0 : o_pull;
    end
  end
endmodule

//--- tb/test_event_latch_validation_gate.sv
`timescale 1ns/1ps
module test_event_latch_validation_gate;
  localparam int SPAN = 10;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [1:0]  recog = 2'h0;
  logic [1:0]  req_val = 2'h0;
  logic [15:0] data = 16'h0;
  logic        ev = 1'b0, acc = 1'b0, hold = 1'b1, fp_in = 1'b1, fp_route = 1'b0;
  logic        start = 1'b0, init_done = 1'b0, eor = 1'b0, force_exit = 1'b0;
  logic        ce = 1'b1, wait_en = 1'b1, align_cfg = 1'b0;
  logic [47:0] t_hold;
  logic        veto_oe, pull, run_oe, wait_rb, align_pend, acq, cfg_en;
  logic [15:0] ldata;
  logic [1:0]  lvalid, lrej;
  logic [47:0] timer;
  logic [42:0] exp_q[$];
  logic [42:0] note;
  int          failures = 0;
  int          n_compared = 0;
  int          cyc = 0;
  int          seed = 32'hdf62;

  // Both shared lines are open drain with pull-ups, so any puller wins.
  wire veto = ~(veto_oe | pull);
  wire run_line = ~(run_oe | hold);

  always #2.5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  event_latch_validation_gate #(.NCH(2), .DW(8), .FW(7)) i_dut (
    .i_clk(clk), .i_rst(rst), .i_ce(ce),
    .i_event_recognized(recog), .i_event_data(data), .i_require_validation(req_val),
    .i_rise_cycles(7'h04), .i_flat_cycles(7'h06),
    .o_latched_data(ldata), .o_latch_valid(lvalid), .o_latch_rejected(lrej),
    .i_backplane_veto_line(veto), .o_backplane_veto_line_oe(veto_oe),
    .i_fp_validation_in(fp_in), .i_fp_route_validation(fp_route),
    .i_run_start_req(start), .i_init_done(init_done), .i_end_of_run(eor),
    .i_force_wait_exit(force_exit), .i_run_start_wait_enable(wait_en),
    .i_timer_align_cfg(align_cfg), .i_run_line(run_line), .o_run_line_oe(run_oe),
    .o_run_start_wait_enable(wait_rb), .o_timer_align_pending(align_pend),
    .o_acquiring(acq), .o_timer(timer), .o_cfg_respond_en(cfg_en));

  veto_partner i_partner (.i_clk(clk), .i_event(ev), .i_accept(acc),
    .i_span(7'(SPAN)), .o_pull(pull));

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // One event on one channel; the note records kind, data and the cycle of the answer.
  task automatic send(input int c, input logic need, input logic ok);
    logic [7:0] d;
    d = 8'($random(seed));
    @(negedge clk);
    req_val[c] = need;
    data[c*8+:8] = d;
    acc = ok;
    recog[c] = 1'b1;
    ev = 1'b1;
    exp_q.push_back({c[0], (ok | !need) ? 2'b10 : 2'b01, d, cyc + SPAN + 1});
    @(negedge clk);
    recog = 2'h0;
    ev = 1'b0;
    repeat (SPAN + 4) @(negedge clk);
  endtask

  // Run start through the sync wait; a forced exit must drop back to idle for good.
  task automatic run_start(input logic by_force);
    @(negedge clk);
    hold = 1'b1;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    check("init_pull", run_oe, 1'b1);
    init_done = 1'b1;
    @(negedge clk);
    init_done = 1'b0;
    repeat (4) @(negedge clk);
    check("wait_pull", run_oe, 1'b0);
    check("wait_flags", {wait_rb, align_pend, acq}, {1'b1, align_cfg, 1'b0});
    if (by_force) begin
      force_exit = 1'b1;
      @(negedge clk);
      force_exit = 1'b0;
      check("forced_exit", acq, 1'b0);
      // A released line must not start a run once the wait has been left.
      hold = 1'b0;
      repeat (6) @(negedge clk);
      check("wait_left", acq, 1'b0);
    end else begin
      hold = 1'b0;
      for (int i = 0; i < 8 && acq !== 1'b1; i++) @(negedge clk);
      check("acquiring", acq, 1'b1);
      check("timer_zeroed", timer == 48'h0, !align_cfg);
    end
  endtask

  // Each result pulse takes the oldest note; an unexpected pulse is a mismatch.
  always @(negedge clk) begin
    for (int c = 0; c < 2; c++) begin
      if (lvalid[c] !== 1'b0 || lrej[c] !== 1'b0) begin
        if (exp_q.size() == 0) check("stray_latch", 1'b1, 1'b0);
        else begin
          note = exp_q.pop_front();
          check("latch_chan", c, note[42]);
          check("latch_kind", {lvalid[c], lrej[c]}, note[41:40]);
          check("latch_time", cyc, note[31:0]);
          if (note[41]) check("latch_data", ldata[c*8+:8], note[39:32]);
        end
      end
    end
  end

  // Watchdog sized well above the few hundred cycles the sequence needs.
  initial begin
    repeat (4000) @(posedge clk);
    failures++;
    stop_test();
  end

  initial begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    check("cfg_respond", cfg_en, 1'b1);
    $display("test reset done");
    run_start(1'b0);
    send(0, 1'b1, 1'b1);
    send(0, 1'b1, 1'b0);
    send(1, 1'b0, 1'b0);
    for (int i = 0; i < 6; i++) send(i % 2, 1'($random(seed)), 1'($random(seed)));
    $display("test latch done");
    fp_route = 1'b1;
    fp_in = 1'b0;
    repeat (3) @(negedge clk);
    check("fp_pull", veto_oe, 1'b1);
    fp_in = 1'b1;
    repeat (3) @(negedge clk);
    check("fp_release", veto_oe, 1'b0);
    fp_route = 1'b0;
    $display("test front panel done");
    eor = 1'b1;
    @(negedge clk);
    eor = 1'b0;
    check("stop_pull", {run_oe, acq}, 2'b10);
    repeat (25) @(negedge clk);
    check("stop_release", run_oe, 1'b0);
    recog = 2'h3;
    repeat (SPAN + 4) @(negedge clk);
    recog = 2'h0;
    $display("test idle events done");
    // Second run keeps its timers, then the enable freezes them and another module stops it.
    align_cfg = 1'b1;
    run_start(1'b0);
    t_hold = timer;
    ce = 1'b0;
    repeat (4) @(negedge clk);
    check("ce_freeze", timer, t_hold);
    ce = 1'b1;
    hold = 1'b1;
    repeat (4) @(negedge clk);
    check("remote_stop", acq, 1'b0);
    $display("test remote stop done");
    align_cfg = 1'b0;
    run_start(1'b1);
    $display("test forced exit done");
    // Without the sync wait the run line is never pulled and remote stops are ignored.
    wait_en = 1'b0;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    check("nowait_init", run_oe, 1'b0);
    init_done = 1'b1;
    @(negedge clk);
    init_done = 1'b0;
    check("nowait_acq", acq, 1'b1);
    hold = 1'b1;
    repeat (4) @(negedge clk);
    check("nowait_hold", acq, 1'b1);
    eor = 1'b1;
    @(negedge clk);
    eor = 1'b0;
    check("nowait_stop", {run_oe, acq}, 2'b00);
    $display("test no wait done");
    check("notes_left", exp_q.size(), 0);
    stop_test();
  end
endmodule
